// ===== verilog/adc_port_pkg.sv
// Functional notes
// - calibration strobe falling edge applies an internal reset before calibration.
// - calibration strobe rising edge starts the selected calibration type and raises busy.
// - full calibration drops busy after DAC and gain phases, then awaits offset trigger.
// - conversion strobe rise after gain phase starts offset phase, busy high until done.
// - gain-plus-offset calibration follows full sequence but skips the DAC phase.
// - offset-only or gain-only calibration holds busy high until it ends.
// - outputs shift on serial clock falls, inputs captured on rises.
// - MSB appears on frame-select fall if clock low, else first clock fall.
// - frame-select high clears shift register; next frame starts at bit one.
// - 3-wire mode after reset; 2-wire only by control register write.
// - conversion starts on conversion strobe pulse or conversion-start bit write.
// - 2-wire data pin turns output after 16th rise, floats while frame-select high.
// - 2-wire data pin returns to input after the 16 read clocks.
// - frame-select tied low: pin never floats, direction flips every 16th rise.
// - calibration register bursts keep one pin direction for every word.
`default_nettype none
package adc_port_pkg;
  localparam int unsigned CLOCK_PERIOD_NS = 10;
  localparam int unsigned FRAME_BITS      = 16;
  // register byte addresses
  localparam logic [31:0] CTRL_ADDR   = 32'h0000_0000;
  localparam logic [31:0] STATUS_ADDR = 32'h0000_0004;
  localparam logic [31:0] TX_ADDR     = 32'h0000_0008;
  localparam logic [31:0] RX_ADDR     = 32'h0000_000C;
  // control fields
  localparam int unsigned CTRL_TWO_WIRE  = 0;
  localparam int unsigned CTRL_CALIBRATE = 1;
  localparam int unsigned CTRL_CONVERT   = 2;
  localparam int unsigned CTRL_TYPE_LSB  = 4;
  localparam int unsigned CTRL_BURST_LSB = 8;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam logic [15:0] TX_RESET       = 16'h0000;
  // status fields
  localparam int unsigned ST_BUSY       = 0;
  localparam int unsigned ST_CONV       = 1;
  localparam int unsigned ST_DIR_OUT    = 2;
  localparam int unsigned ST_TWO_WIRE   = 3;
  localparam int unsigned ST_STATE_LSB  = 4;
  localparam int unsigned ST_COUNT_LSB  = 8;
  localparam int unsigned ST_FRAMES_LSB = 16;
  // calibration type codes
  localparam logic [1:0] CAL_TYPE_FULL        = 2'h0;
  localparam logic [1:0] CAL_TYPE_GAIN_OFFSET = 2'h1;
  localparam logic [1:0] CAL_TYPE_OFFSET      = 2'h2;
  localparam logic [1:0] CAL_TYPE_GAIN        = 2'h3;
  // phase durations
  localparam int unsigned DAC_CAL_TIME_NS       = 24310000;
  localparam int unsigned GAIN_CAL_TIME_NS      = 3470000;
  localparam int unsigned offset_phase_duration = 3470000;
  localparam int unsigned CONVERSION_TIME_NS    = 4600;
  localparam int unsigned DAC_CAL_CYCLES_DEF    = DAC_CAL_TIME_NS / CLOCK_PERIOD_NS;
  localparam int unsigned GAIN_CAL_CYCLES_DEF   = GAIN_CAL_TIME_NS / CLOCK_PERIOD_NS;
  localparam int unsigned OFFSET_CAL_CYCLES_DEF = offset_phase_duration / CLOCK_PERIOD_NS;
  localparam int unsigned CONVERSION_CYCLES_DEF = CONVERSION_TIME_NS / CLOCK_PERIOD_NS;
  // pin indices of the synchroniser bank
  localparam int unsigned PIN_SCLK  = 0;
  localparam int unsigned PIN_FRAME = 1;
  localparam int unsigned PIN_DATA  = 2;
  localparam int unsigned PIN_CAL   = 3;
  localparam int unsigned PIN_CONV  = 4;
  localparam int unsigned PIN_COUNT = 5;
  typedef enum logic [2:0] {
    CAL_IDLE, CAL_RESET, CAL_DAC, CAL_GAIN, CAL_WAIT_OFFSET, CAL_OFFSET, CAL_SINGLE
  } cal_state_t;
endpackage
`default_nettype wire

// ===== verilog/adc_serial_port_and_syscal.sv
// Our own choices: the register addresses and register access over AHB-Lite.
`default_nettype none
module adc_serial_port_and_syscal
  import adc_port_pkg::*;
#(
  parameter int unsigned DAC_CAL_CYCLES    = DAC_CAL_CYCLES_DEF,
  parameter int unsigned GAIN_CAL_CYCLES   = GAIN_CAL_CYCLES_DEF,
  parameter int unsigned OFFSET_CAL_CYCLES = OFFSET_CAL_CYCLES_DEF,
  parameter int unsigned CONVERSION_CYCLES = CONVERSION_CYCLES_DEF
) (
  input  wire logic        CLOCK_I,
  input  wire logic        RESET_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output var  logic [31:0] HRDATA_O,
  output var  logic        HREADYOUT_O,
  output var  logic        HRESP_O,
  input  wire logic        SCLK_I,
  input  wire logic        FRAME_SELECT_N_I,
  input  wire logic        DIN_I,
  output var  logic        DIN_O,
  output var  logic        DIN_OE_O,
  output var  logic        DOUT_O,
  output var  logic        DOUT_OE_O,
  input  wire logic        CALIBRATION_STROBE_N_I,
  input  wire logic        CONVERSION_STROBE_N_I,
  output var  logic        BUSY_O
);

  if (DAC_CAL_CYCLES < 1 || GAIN_CAL_CYCLES < 1 || OFFSET_CAL_CYCLES < 1 ||
      CONVERSION_CYCLES < 1) begin : bad_cycles
    $error("calibration and conversion counts must be at least one cycle");
  end

  // pin synchronisers: a level counts once stages two and three agree
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] stage1;
  logic [PIN_COUNT-1:0] stage2;
  logic [PIN_COUNT-1:0] stage3;
  logic [PIN_COUNT-1:0] lvl;
  logic [PIN_COUNT-1:0] lvl_q;
  assign pin_raw = {CONVERSION_STROBE_N_I, CALIBRATION_STROBE_N_I, DIN_I,
                    FRAME_SELECT_N_I, SCLK_I};

  for (genvar g = 0; g < PIN_COUNT; g++) begin : pin_sync
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
        stage1[g] <= 1'b1;
        stage2[g] <= 1'b1;
        stage3[g] <= 1'b1;
        lvl[g]    <= 1'b1;
        lvl_q[g]  <= 1'b1;
      end else begin
        stage1[g] <= pin_raw[g];
        stage2[g] <= stage1[g];
        stage3[g] <= stage2[g];
        if (stage2[g] == stage3[g]) begin
          lvl[g] <= stage3[g];
        end
        lvl_q[g] <= lvl[g];
      end
    end
  end

  logic sclk_rise, sclk_fall, frame_high, frame_fall, cal_fall, cal_rise, conv_rise;
  assign sclk_rise  = lvl[PIN_SCLK] & ~lvl_q[PIN_SCLK];
  assign sclk_fall  = ~lvl[PIN_SCLK] & lvl_q[PIN_SCLK];
  assign frame_high = lvl[PIN_FRAME];
  assign frame_fall = ~lvl[PIN_FRAME] & lvl_q[PIN_FRAME];
  assign cal_fall   = ~lvl[PIN_CAL] & lvl_q[PIN_CAL];
  assign cal_rise   = lvl[PIN_CAL] & ~lvl_q[PIN_CAL];
  assign conv_rise  = lvl[PIN_CONV] & ~lvl_q[PIN_CONV];

  // AHB-Lite slave, zero wait states
  logic        take;
  logic        dp_write;
  logic [31:0] dp_addr;
  assign take = HSEL_I & HTRANS_I[1] & HREADY_I;

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      dp_write    <= 1'b0;
      dp_addr     <= 32'h0000_0000;
      HREADYOUT_O <= 1'b0;
      HRESP_O     <= 1'b0;
    end else begin
      dp_write    <= take & HWRITE_I;
      dp_addr     <= HADDR_I;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
  end

  logic wr_ctrl, wr_tx, sw_cal, sw_conv;
  assign wr_ctrl = dp_write && (dp_addr == CTRL_ADDR);
  assign wr_tx   = dp_write && (dp_addr == TX_ADDR);
  assign sw_cal  = wr_ctrl && HWDATA_I[CTRL_CALIBRATE];
  assign sw_conv = wr_ctrl && HWDATA_I[CTRL_CONVERT];

  logic        two_wire;
  logic [1:0]  cal_type;
  logic [3:0]  burst_cfg;
  logic [15:0] tx_word;
  logic        conv_bit;
  logic        conv_active;
  logic        conv_done;

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      two_wire  <= CTRL_RESET[CTRL_TWO_WIRE];
      cal_type  <= CTRL_RESET[CTRL_TYPE_LSB +: 2];
      burst_cfg <= CTRL_RESET[CTRL_BURST_LSB +: 4];
      tx_word   <= TX_RESET;
    end else begin
      if (wr_ctrl) begin
        two_wire  <= HWDATA_I[CTRL_TWO_WIRE];
        cal_type  <= HWDATA_I[CTRL_TYPE_LSB +: 2];
        burst_cfg <= HWDATA_I[CTRL_BURST_LSB +: 4];
      end
      if (wr_tx) begin
        tx_word <= HWDATA_I[15:0];
      end
    end
  end

  // calibration sequencer
  cal_state_t  cal_state;
  cal_state_t  start_state;
  logic [31:0] cal_count;
  logic [31:0] start_count;
  logic        internal_reset;
  assign internal_reset = (cal_state == CAL_RESET);

  always_comb begin
    start_state = CAL_SINGLE;
    start_count = 32'(OFFSET_CAL_CYCLES - 1);
    if (cal_type == CAL_TYPE_FULL) begin
      start_state = CAL_DAC;
      start_count = 32'(DAC_CAL_CYCLES - 1);
    end else if (cal_type == CAL_TYPE_GAIN_OFFSET) begin
      start_state = CAL_GAIN;
      start_count = 32'(GAIN_CAL_CYCLES - 1);
    end else if (cal_type == CAL_TYPE_GAIN) begin
      start_count = 32'(GAIN_CAL_CYCLES - 1);
    end
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      cal_state <= CAL_IDLE;
      cal_count <= 32'h0000_0000;
    end else if (cal_fall) begin
      cal_state <= CAL_RESET;
      cal_count <= 32'h0000_0000;
    end else begin
      case (cal_state)
        CAL_IDLE: begin
          if (sw_cal) begin
            cal_state <= start_state;
            cal_count <= start_count;
          end
        end
        CAL_RESET: begin
          if (cal_rise) begin
            cal_state <= start_state;
            cal_count <= start_count;
          end
        end
        CAL_DAC: begin
          if (cal_count == 32'h0000_0000) begin
            cal_state <= CAL_GAIN;
            cal_count <= 32'(GAIN_CAL_CYCLES - 1);
          end else begin
            cal_count <= cal_count - 32'h0000_0001;
          end
        end
        CAL_GAIN: begin
          if (cal_count == 32'h0000_0000) begin
            cal_state <= CAL_WAIT_OFFSET;
          end else begin
            cal_count <= cal_count - 32'h0000_0001;
          end
        end
        CAL_WAIT_OFFSET: begin
          if (conv_rise) begin
            cal_state <= CAL_OFFSET;
            cal_count <= 32'(OFFSET_CAL_CYCLES - 1);
          end
        end
        default: begin
          if (cal_count == 32'h0000_0000) begin
            cal_state <= CAL_IDLE;
          end else begin
            cal_count <= cal_count - 32'h0000_0001;
          end
        end
      endcase
    end
  end

  // conversions, aborted by any calibration activity
  logic [31:0] conv_count;
  assign conv_done = conv_active && (conv_count == 32'h0000_0000);

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      conv_active <= 1'b0;
      conv_count  <= 32'h0000_0000;
    end else if (cal_state != CAL_IDLE || cal_fall) begin
      conv_active <= 1'b0;
    end else if (!conv_active) begin
      if (conv_rise || sw_conv) begin
        conv_active <= 1'b1;
        conv_count  <= 32'(CONVERSION_CYCLES - 1);
      end
    end else if (conv_done) begin
      conv_active <= 1'b0;
    end else begin
      conv_count <= conv_count - 32'h0000_0001;
    end
  end

  // software start bit reads back until the conversion ends; a new write wins
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      conv_bit <= CTRL_RESET[CTRL_CONVERT];
    end else if (sw_conv) begin
      conv_bit <= 1'b1;
    end else if (conv_done || !conv_active) begin
      conv_bit <= 1'b0;
    end
  end

  logic cal_busy;
  assign cal_busy = (cal_state == CAL_DAC) || (cal_state == CAL_GAIN) ||
                    (cal_state == CAL_OFFSET) || (cal_state == CAL_SINGLE);

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      BUSY_O <= 1'b0;
    end else begin
      BUSY_O <= cal_busy || conv_active;
    end
  end

  // serial engine
  logic [4:0]  bit_count;
  logic [15:0] shift_in;
  logic [15:0] shift_out;
  logic [15:0] rx_word;
  logic [7:0]  rx_frames;
  logic [3:0]  words_left;
  logic        out_started;
  logic        dir_out;
  logic        receiving;
  assign receiving = !(two_wire && dir_out);

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      bit_count   <= 5'h00;
      shift_in    <= 16'h0000;
      shift_out   <= 16'h0000;
      rx_word     <= 16'h0000;
      rx_frames   <= 8'h00;
      words_left  <= 4'h0;
      out_started <= 1'b0;
      dir_out     <= 1'b0;
    end else if (frame_high || internal_reset) begin
      bit_count   <= 5'h00;
      shift_in    <= 16'h0000;
      shift_out   <= tx_word;
      out_started <= 1'b0;
      if (!two_wire || internal_reset) begin
        dir_out    <= 1'b0;
        words_left <= burst_cfg;
      end
    end else begin
      if (frame_fall && !lvl[PIN_SCLK]) begin
        out_started <= 1'b1;
      end
      if (sclk_rise) begin
        if (receiving) begin
          shift_in <= {shift_in[14:0], lvl[PIN_DATA]};
        end
        if (bit_count == 5'(FRAME_BITS - 1)) begin
          bit_count   <= 5'h00;
          shift_out   <= tx_word;
          out_started <= 1'b0;
          if (receiving) begin
            rx_word   <= {shift_in[14:0], lvl[PIN_DATA]};
            rx_frames <= rx_frames + 8'h01;
          end
          if (!two_wire) begin
            dir_out <= 1'b0;
          end else if (words_left != 4'h0) begin
            words_left <= words_left - 4'h1;
          end else begin
            dir_out    <= ~dir_out;
            words_left <= burst_cfg;
          end
        end else begin
          bit_count <= bit_count + 5'h01;
        end
      end else if (sclk_fall) begin
        if (!out_started) begin
          out_started <= 1'b1;
        end else begin
          shift_out <= {shift_out[14:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      DOUT_O    <= 1'b0;
      DOUT_OE_O <= 1'b0;
      DIN_O     <= 1'b0;
      DIN_OE_O  <= 1'b0;
    end else begin
      DOUT_O    <= out_started & shift_out[15];
      DOUT_OE_O <= !two_wire && !frame_high;
      DIN_O     <= out_started & shift_out[15];
      DIN_OE_O  <= two_wire && dir_out && !frame_high;
    end
  end

  // register read data
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_BUSY] = cal_busy || conv_active;
    status_word[ST_CONV] = conv_bit;
    status_word[ST_DIR_OUT] = dir_out;
    status_word[ST_TWO_WIRE] = two_wire;
    status_word[ST_STATE_LSB +: 3] = cal_state;
    status_word[ST_COUNT_LSB +: 5] = bit_count;
    status_word[ST_FRAMES_LSB +: 8] = rx_frames;
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      HRDATA_O <= 32'h0000_0000;
    end else if (take && !HWRITE_I) begin
      if (HADDR_I == CTRL_ADDR) begin
        HRDATA_O <= {20'h0_0000, burst_cfg, 2'h0, cal_type, 1'b0, conv_bit, 1'b0, two_wire};
      end else if (HADDR_I == STATUS_ADDR) begin
        HRDATA_O <= status_word;
      end else if (HADDR_I == TX_ADDR) begin
        HRDATA_O <= {16'h0000, tx_word};
      end else if (HADDR_I == RX_ADDR) begin
        HRDATA_O <= {16'h0000, rx_word};
      end else begin
        HRDATA_O <= 32'h0000_0000;
      end
    end
  end

  // checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);

  sequence busy_next_s;
    ##1 BUSY_O;
  endsequence

  cal_reset_entry_a: assert property (cal_fall |=> cal_state == CAL_RESET)
    else $error("strobe fall did not enter internal reset");
  dac_start_a: assert property (internal_reset && cal_rise && !cal_fall &&
      cal_type == CAL_TYPE_FULL |=> cal_state == CAL_DAC ##0 busy_next_s)
    else $error("full calibration did not start DAC phase with busy");
  gain_done_a: assert property (cal_state == CAL_GAIN && cal_count == 0 && !cal_fall
      |=> cal_state == CAL_WAIT_OFFSET ##1 !BUSY_O)
    else $error("busy not low after gain phase");
  offset_start_a: assert property (cal_state == CAL_WAIT_OFFSET && conv_rise && !cal_fall
      |=> cal_state == CAL_OFFSET ##0 busy_next_s)
    else $error("offset phase did not start on conversion strobe");
  skip_dac_a: assert property (internal_reset && cal_rise && !cal_fall &&
      cal_type == CAL_TYPE_GAIN_OFFSET |=> cal_state == CAL_GAIN)
    else $error("gain plus offset calibration entered DAC phase");
  single_busy_a: assert property ($rose(cal_state == CAL_SINGLE) |=> BUSY_O)
    else $error("single calibration without busy");
  capture_edge_a: assert property ($changed(shift_in) |->
      $past(sclk_rise || frame_high || internal_reset))
    else $error("shift register moved without a rising serial clock");
  early_msb_a: assert property (frame_fall && !lvl[PIN_SCLK] && !internal_reset
      |=> out_started ##1 DOUT_O == shift_out[15])
    else $error("MSB not presented on frame-select fall");
  frame_clear_a: assert property (frame_high |=> bit_count == 0 && shift_in == 0)
    else $error("frame-select high did not clear the shift state");
  mode_hold_a: assert property (!wr_ctrl |=> two_wire == $past(two_wire))
    else $error("interface mode changed without a control write");
  conv_start_a: assert property (cal_state == CAL_IDLE && !cal_fall && !conv_active &&
      conv_rise |=> conv_active ##0 busy_next_s)
    else $error("conversion strobe did not start a conversion");
  float_high_a: assert property (frame_high |=> !DIN_OE_O && !DOUT_OE_O)
    else $error("data pin driven while frame-select high");
  dir_turn_a: assert property (two_wire && sclk_rise && !frame_high && !internal_reset &&
      bit_count == 5'(FRAME_BITS - 1) && words_left == 0 |=> dir_out != $past(dir_out))
    else $error("direction did not switch at sixteenth rise");
  burst_hold_a: assert property (sclk_rise && words_left != 0 && two_wire &&
      !frame_high && !internal_reset |=> dir_out == $past(dir_out))
    else $error("direction switched inside a burst");
  count_bound_a: assert property (bit_count < 5'(FRAME_BITS))
    else $error("edge counter passed sixteen");

endmodule // adc_serial_port_and_syscal
`default_nettype wire

// ===== tb/host_serial_model.sv
`default_nettype none
module host_serial_model (
  output var  logic sclk_o,
  output var  logic fs_n_o,
  output wire logic din_o,
  input  wire logic dout_i,
  input  wire logic dout_oe_i,
  input  wire logic dev_i,
  input  wire logic dev_oe_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic two_wire = 1'b0;
  logic hdrv     = 1'b0;
  logic hbit     = 1'b0;
  logic junk     = 1'b0;
  logic low_start = 1'b0;
  logic line;
  // released lines show a toggling pattern, never a held value
  assign line  = dev_oe_i ? dev_i : (hdrv ? hbit : junk);
  assign din_o = two_wire ? line : (hdrv ? hbit : junk);
  initial begin
    sclk_o = 1'b1;
    fs_n_o = 1'b1;
  end
  // bits on falls, idle clock high, frame select around nb clocks
  task automatic xfer(input logic [15:0] tx, input logic drv, input int nb,
                      output logic [15:0] rx);
    rx     = '0;
    // step off the system clock edges
    #2;
    // clock already low at frame-select fall
    if (low_start) begin
      sclk_o = 1'b0;
      #50;
    end
    fs_n_o = 1'b0;
    hdrv   = drv;
    #100;
    for (int i = 15; i > 15 - nb; i--) begin
      sclk_o = 1'b0;
      hbit   = tx[i];
      junk   = ~junk;
      #40;
      sclk_o = 1'b1;
      #39;
      // late in the high phase: device output trails the fall by several cycles
      rx[i] = two_wire ? line : (dout_oe_i ? dout_i : junk);
      #1;
    end
    hdrv = 1'b0;
    #100;
    fs_n_o = 1'b1;
    #200;
  endtask
endmodule // host_serial_model
`default_nettype wire

// ===== tb/adc_serial_port_and_syscal_tb.sv
`default_nettype none
module adc_serial_port_and_syscal_tb;
  import adc_port_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DC = 20;
  localparam int GC = 10;
  localparam int OC = 10;
  localparam int CC = 8;
  localparam int input_settle_time = 100;
  logic        clk    = 1'b0;
  logic        rst    = 1'b1;
  logic [31:0] haddr  = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic        cal_n  = 1'b1;
  logic        conv_n = 1'b1;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hready, hresp, sclk, fs_n, din, din_o, din_oe, dout, dout_oe, busy;
  logic [15:0] rx;
  int          num_errors   = 0;
  int          total_checks = 0;
  int          cycles       = 0;
  int          n;
  int          lo[4]  = '{DC + GC, GC, OC, GC};
  logic [31:0] ph1[4] = '{32'h0000_0021, 32'h0000_0031, 32'h0000_0061, 32'h0000_0061};

  adc_serial_port_and_syscal #(.DAC_CAL_CYCLES(DC), .GAIN_CAL_CYCLES(GC),
    .OFFSET_CAL_CYCLES(OC), .CONVERSION_CYCLES(CC)) u_adc_serial_port_and_syscal (
    .CLOCK_I(clk), .RESET_I(rst), .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .SCLK_I(sclk),
    .FRAME_SELECT_N_I(fs_n), .DIN_I(din), .DIN_O(din_o), .DIN_OE_O(din_oe),
    .DOUT_O(dout), .DOUT_OE_O(dout_oe), .CALIBRATION_STROBE_N_I(cal_n),
    .CONVERSION_STROBE_N_I(conv_n), .BUSY_O(busy));

  host_serial_model u_host_serial_model (.sclk_o(sclk), .fs_n_o(fs_n), .din_o(din),
    .dout_i(dout), .dout_oe_i(dout_oe), .dev_i(din_o), .dev_oe_i(din_oe));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", w, e, s);
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0000_0000);
  endtask

  task automatic rdc(input string w, input logic [31:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    ahb(1'b0, a, '0);
    chk(w, rd & m, e);
  endtask

  task automatic wait_busy(input logic v, output int cnt);
    cnt = 0;
    while (busy !== v) begin
      @(posedge clk);
      cnt++;
    end
  endtask

  task automatic pulse(input bit conv);
    if (conv) conv_n <= 1'b0;
    else cal_n <= 1'b0;
    // input level settles before the strobe rises
    repeat (input_settle_time / 10) @(posedge clk);
    if (!conv) rdc("reset state", STATUS_ADDR, 32'h0000_0071, 32'h0000_0010);
    conv_n <= 1'b1;
    cal_n  <= 1'b1;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc("ctrl reset", CTRL_ADDR, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc("mode reset", STATUS_ADDR, 32'h0000_000F, 32'h0000_0000);
    ahb(1'b1, 32'h0000_0010, 32'hFFFF_FFFF);
    rdc("unmapped", 32'h0000_0010, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("test registers done");
    ahb(1'b1, TX_ADDR, 32'h0000_A5C3);
    // first word shifts out the TX word A5C3 and shifts in 4002
    u_host_serial_model.xfer(16'h4002, 1'b1, 16, rx);
    chk("dout word", {16'h0000, rx}, 32'h0000_A5C3);
    rdc("rx word", RX_ADDR, 32'h0000_FFFF, 32'h0000_4002);
    u_host_serial_model.xfer(16'hFFFF, 1'b1, 5, rx);
    u_host_serial_model.xfer(16'h1234, 1'b1, 16, rx);
    rdc("rx after abort", RX_ADDR, 32'h0000_FFFF, 32'h0000_1234);
    rdc("frames", STATUS_ADDR, 32'h00FF_0000, 32'h0002_0000);
    u_host_serial_model.low_start = 1'b1;
    u_host_serial_model.xfer(16'h0F0F, 1'b1, 16, rx);
    u_host_serial_model.low_start = 1'b0;
    chk("early msb word", {16'h0000, rx}, 32'h0000_A5C3);
    $display("test three wire done");
    for (int t = 0; t < 4; t++) begin
      ahb(1'b1, CTRL_ADDR, 32'(t) << CTRL_TYPE_LSB);
      pulse(1'b0);
      wait_busy(1'b1, n);
      rdc("first phase", STATUS_ADDR, 32'h0000_0071, ph1[t]);
      wait_busy(1'b0, n);
      chk("busy span", 32'(n >= lo[t] - 4 && n <= lo[t] + 6), 32'h0000_0001);
      if (t < 2) begin
        repeat (20) @(posedge clk);
        rdc("wait offset", STATUS_ADDR, 32'h0000_0071, 32'h0000_0040);
        pulse(1'b1);
        wait_busy(1'b1, n);
        rdc("offset phase", STATUS_ADDR, 32'h0000_0071, 32'h0000_0051);
        wait_busy(1'b0, n);
      end
      rdc("cal idle", STATUS_ADDR, 32'h0000_0071, 32'h0000_0000);
    end
    ahb(1'b1, CTRL_ADDR, 32'h0000_0032);
    wait_busy(1'b1, n);
    rdc("soft cal", STATUS_ADDR, 32'h0000_0071, 32'h0000_0061);
    wait_busy(1'b0, n);
    $display("test calibration done");
    ahb(1'b1, CTRL_ADDR, 32'h0000_0100);
    ahb(1'b1, CTRL_ADDR, 32'h0000_0101);
    rdc("two wire on", STATUS_ADDR, 32'h0000_000C, 32'h0000_0008);
    ahb(1'b1, TX_ADDR, 32'h0000_BEEF);
    u_host_serial_model.two_wire = 1'b1;
    u_host_serial_model.xfer(16'h8421, 1'b1, 16, rx);
    rdc("dir held in", STATUS_ADDR, 32'h0000_0004, 32'h0000_0000);
    u_host_serial_model.xfer(16'hC001, 1'b1, 16, rx);
    rdc("dir out", STATUS_ADDR, 32'h0000_0004, 32'h0000_0004);
    chk("float fs high", {31'h0, din_oe}, 32'h0000_0000);
    rdc("rx two wire", RX_ADDR, 32'h0000_FFFF, 32'h0000_C001);
    u_host_serial_model.xfer(16'h0000, 1'b0, 16, rx);
    chk("burst word", {16'h0000, rx}, 32'h0000_BEEF);
    rdc("dir held out", STATUS_ADDR, 32'h0000_0004, 32'h0000_0004);
    u_host_serial_model.xfer(16'h0000, 1'b0, 16, rx);
    chk("read word", {16'h0000, rx}, 32'h0000_BEEF);
    rdc("dir back in", STATUS_ADDR, 32'h0000_0004, 32'h0000_0000);
    $display("test two wire done");
    // wire-count bit kept set in two-wire writes
    ahb(1'b1, CTRL_ADDR, 32'h0000_0005);
    rdc("conv bit set", CTRL_ADDR, 32'h0000_0005, 32'h0000_0005);
    wait_busy(1'b0, n);
    rdc("conv bit clear", CTRL_ADDR, 32'h0000_0005, 32'h0000_0001);
    pulse(1'b1);
    wait_busy(1'b1, n);
    wait_busy(1'b0, n);
    chk("conv span", 32'(n >= CC - 2 && n <= CC + 2), 32'h0000_0001);
    $display("test conversion done");
    close_out();
  end
endmodule // adc_serial_port_and_syscal_tb
`default_nettype wire
